// file: counter_array_pkg.sv
// Package with register map, field positions and timing constants of the counter array.
`default_nettype none
package counter_array_pkg;
  localparam int unsigned NUM_MODULES = 2;
  localparam logic [7:0] OFF_CONTROL  = 8'h00;
  localparam logic [7:0] OFF_MODE     = 8'h04;
  localparam logic [7:0] OFF_CNT_LO   = 8'h08;
  localparam logic [7:0] OFF_CNT_HI   = 8'h0C;
  localparam logic [7:0] OFF_IRQ_EN   = 8'h10;
  localparam logic [7:0] OFF_MOD_BASE = 8'h20;
  localparam logic [7:0] OFF_MOD_STEP = 8'h10;
  localparam logic [7:0] OFF_CAP_LO   = 8'h04;
  localparam logic [7:0] OFF_CAP_HI   = 8'h08;
  // Mode register fields.
  localparam int unsigned MODE_IDLE_STOP = 7;
  localparam int unsigned MODE_TB_HI     = 2;
  localparam int unsigned MODE_TB_LO     = 1;
  localparam int unsigned MODE_OVF_IE    = 0;
  // Control register fields: overflow flag, event flags from bit 0.
  localparam int unsigned CTRL_OVF_FLAG  = 7;
  // Module mode register fields.
  localparam int unsigned MM_RISE        = 5;
  localparam int unsigned MM_FALL        = 4;
  localparam int unsigned MM_EVT_IE      = 0;
  // Interrupt enable register fields.
  localparam int unsigned IE_GLOBAL      = 7;
  localparam int unsigned IE_COUNTER     = 0;
  localparam logic [1:0] TB_DIV12 = 2'h0;
  localparam logic [1:0] TB_DIV4  = 2'h1;
  localparam logic [1:0] TB_T0OVF = 2'h2;
  localparam logic [1:0] TB_EXT   = 2'h3;
  localparam logic [3:0] DIV12_LAST = 4'hB;
  localparam logic [3:0] DIV4_LAST  = 4'h3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : counter_array_pkg
`default_nettype wire

// file: capture_module.sv
// One capture module: edge select, capture register and event flag.
`default_nettype none
module capture_module
  import counter_array_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        run,
  input  wire logic        pin_sync,
  input  wire logic [15:0] count,
  input  wire logic        rise_en,
  input  wire logic        fall_en,
  input  wire logic        flag_clear,
  output logic      [15:0] capture_r,
  output logic             flag_r
);
  logic prev_r;
  logic hit;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
    end else begin
      prev_r <= pin_sync;
    end
  end

  // The edge history keeps tracking while halted so no stale edge fires on resume.
  assign hit = run && ((rise_en && pin_sync && !prev_r) ||
                       (fall_en && !pin_sync && prev_r));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_r <= 16'h0000;
    end else if (hit) begin
      capture_r <= count;
    end
  end

  // A capture in the same cycle as a clear keeps the flag set.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_r <= 1'b0;
    end else if (hit) begin
      flag_r <= 1'b1;
    end else if (flag_clear) begin
      flag_r <= 1'b0;
    end
  end

  capture_loads_a: assert property (@(posedge clk) disable iff (!rst_n)
    hit |=> (capture_r == $past(count)) && flag_r)
    else $error("capture register or flag not loaded on edge");
  flag_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
    flag_r && !flag_clear |=> flag_r)
    else $error("event flag dropped without a software clear");
  capture_cov: cover property (@(posedge clk) disable iff (!rst_n) hit);
endmodule : capture_module
`default_nettype wire

// file: counter_array.sv
// Counter array top: 16-bit timebase counter, capture modules and AXI4-Lite registers.
// Overview of operation
// - A qualifying capture pin edge copies the counter into the module's capture register.
// - Rising and falling enables select rising, falling or both edges.
// - A capture sets the module event flag and may raise an interrupt.
// - The event flag stays set until software clears it.
// - The counter is 16 bits, read as a low and a high byte.
// - Reading the low byte snapshots the high byte for a later high read.
// - Reading the count bytes never disturbs counting.
// - Timebase select picks clock/12, clock/4, timer 0 overflow or external falls.
// - A wrap from FFFF to 0000 sets the overflow flag.
// - The overflow interrupt enable gates the overflow interrupt request.
// - Only software clears the overflow flag.
// - Interrupts need both the global and the counter array enable bits.
// - With idle stop set the counter and modules halt in idle.
//
// Added by the designer: the AXI4-Lite register port and the register addresses.
`default_nettype none
module counter_array
  import counter_array_pkg::*;
(
  input  wire logic                   sys_clk,
  input  wire logic                   resetn,
  input  wire logic                   core_idle,
  input  wire logic                   timer0_overflow,
  input  wire logic                   external_count_input,
  input  wire logic [NUM_MODULES-1:0] capture_pin,
  input  wire logic [7:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [7:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  output logic                        irq_r
);
  logic                   rst_meta_r;
  logic                   rst_n;
  logic [NUM_MODULES-1:0] cap_meta_r;
  logic [NUM_MODULES-1:0] cap_sync_r;
  logic                   eci_meta_r;
  logic                   eci_sync_r;
  logic                   eci_prev_r;
  logic [3:0]             div_r;
  logic [15:0]            count_r;
  logic [7:0]             hi_snap_r;
  logic [7:0]             mode_r;
  logic [7:0]             ie_r;
  logic                   ovf_flag_r;
  logic [7:0]             mm_r [NUM_MODULES];
  logic [15:0]            cap_val [NUM_MODULES];
  logic [NUM_MODULES-1:0] evt_flag;
  logic [NUM_MODULES-1:0] evt_clear;
  logic                   ovf_clear;
  logic                   run;
  logic                   tick;
  logic                   div_last;
  logic [1:0]             tb_sel;
  logic                   aw_held_r;
  logic                   w_held_r;
  logic [7:0]             awaddr_r;
  logic [31:0]            wdata_r;
  logic [3:0]             wstrb_r;
  logic                   wr_go;
  logic                   rd_go;
  logic                   rd_lo;
  logic                   wr_ctrl;
  logic                   irq_nxt;

  // Module registers sit at base + index*step; returns the index or NUM_MODULES if none.
  function automatic int unsigned mod_index(input logic [7:0] addr);
    mod_index = NUM_MODULES;
    for (int unsigned i = 0; i < NUM_MODULES; i++) begin
      if (addr >= OFF_MOD_BASE + 8'(i) * OFF_MOD_STEP &&
          addr <  OFF_MOD_BASE + 8'(i + 1) * OFF_MOD_STEP) begin
        mod_index = i;
      end
    end
  endfunction : mod_index

  function automatic logic [7:0] mod_offset(input logic [7:0] addr);
    mod_offset = (addr - OFF_MOD_BASE) % OFF_MOD_STEP;
  endfunction : mod_offset

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cap_meta_r <= '0;
      cap_sync_r <= '0;
      eci_meta_r <= 1'b0;
      eci_sync_r <= 1'b0;
      eci_prev_r <= 1'b0;
    end else begin
      cap_meta_r <= capture_pin;
      cap_sync_r <= cap_meta_r;
      eci_meta_r <= external_count_input;
      eci_sync_r <= eci_meta_r;
      eci_prev_r <= eci_sync_r;
    end
  end

  assign run    = !(core_idle && mode_r[MODE_IDLE_STOP]);
  assign tb_sel = {mode_r[MODE_TB_HI], mode_r[MODE_TB_LO]};
  assign div_last = (tb_sel == TB_DIV12) ? (div_r == DIV12_LAST) : (div_r == DIV4_LAST);

  // The prescaler free-runs, so after a change to clock/4 a count above 3 runs on to 12 before it wraps.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= 4'h0;
    end else if (div_last || div_r > DIV12_LAST) begin
      div_r <= 4'h0;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  always_comb begin
    unique case (tb_sel)
      TB_DIV12: tick = div_last;
      TB_DIV4:  tick = div_last;
      TB_T0OVF: tick = timer0_overflow;
      TB_EXT:   tick = eci_prev_r && !eci_sync_r;
    endcase
  end

  // Reads never touch the counter; only the timebase tick moves it.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= 16'h0000;
    end else if (run && tick) begin
      count_r <= count_r + 16'h0001;
    end
  end

  // Write logic: address and data are taken in either order.
  assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h0000_0000;
      wstrb_r       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_held_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awaddr_r[1:0] == 2'h0 &&
                         (awaddr_r <= OFF_IRQ_EN || mod_index(awaddr_r) < NUM_MODULES))
                        ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign wr_ctrl = wr_go && awaddr_r == OFF_CONTROL && wstrb_r[0];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_r <= 8'h00;
      ie_r   <= 8'h00;
      for (int i = 0; i < NUM_MODULES; i++) mm_r[i] <= 8'h00;
    end else if (wr_go && wstrb_r[0]) begin
      if (awaddr_r == OFF_MODE) mode_r <= wdata_r[7:0];
      if (awaddr_r == OFF_IRQ_EN) ie_r <= wdata_r[7:0];
      for (int i = 0; i < NUM_MODULES; i++) begin
        if (mod_index(awaddr_r) == i && mod_offset(awaddr_r) == 8'h00) begin
          mm_r[i] <= wdata_r[7:0];
        end
      end
    end
  end

  // Flags clear when software writes a zero to them in the control register.
  assign ovf_clear = wr_ctrl && !wdata_r[CTRL_OVF_FLAG];
  always_comb begin
    for (int i = 0; i < NUM_MODULES; i++) evt_clear[i] = wr_ctrl && !wdata_r[i];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ovf_flag_r <= 1'b0;
    end else if (run && tick && count_r == 16'hFFFF) begin
      ovf_flag_r <= 1'b1;
    end else if (ovf_clear) begin
      ovf_flag_r <= 1'b0;
    end
  end

  for (genvar g = 0; g < NUM_MODULES; g++) begin : g_mod
    capture_module u_mod (
      .clk        (sys_clk),
      .rst_n      (rst_n),
      .run        (run),
      .pin_sync   (cap_sync_r[g]),
      .count      (count_r),
      .rise_en    (mm_r[g][MM_RISE]),
      .fall_en    (mm_r[g][MM_FALL]),
      .flag_clear (evt_clear[g]),
      .capture_r  (cap_val[g]),
      .flag_r     (evt_flag[g])
    );
  end

  always_comb begin
    irq_nxt = mode_r[MODE_OVF_IE] && ovf_flag_r;
    for (int i = 0; i < NUM_MODULES; i++) begin
      irq_nxt = irq_nxt || (mm_r[i][MM_EVT_IE] && evt_flag[i]);
    end
    irq_nxt = irq_nxt && ie_r[IE_GLOBAL] && ie_r[IE_COUNTER];
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // Read logic: one read at a time, data registered with rvalid.
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign rd_lo = rd_go && s_axi_araddr == OFF_CNT_LO;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_snap_r <= 8'h00;
    end else if (rd_lo) begin
      hi_snap_r <= count_r[15:8];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= RESP_OKAY;
        s_axi_rdata  <= 32'h0000_0000;
        if (s_axi_araddr == OFF_CONTROL) begin
          s_axi_rdata[CTRL_OVF_FLAG]   <= ovf_flag_r;
          s_axi_rdata[NUM_MODULES-1:0] <= evt_flag;
        end else if (s_axi_araddr == OFF_MODE) begin
          s_axi_rdata[7:0] <= mode_r;
        end else if (s_axi_araddr == OFF_CNT_LO) begin
          s_axi_rdata[7:0] <= count_r[7:0];
        end else if (s_axi_araddr == OFF_CNT_HI) begin
          s_axi_rdata[7:0] <= hi_snap_r;
        end else if (s_axi_araddr == OFF_IRQ_EN) begin
          s_axi_rdata[7:0] <= ie_r;
        end else if (mod_index(s_axi_araddr) < NUM_MODULES && s_axi_araddr[1:0] == 2'h0) begin
          for (int i = 0; i < NUM_MODULES; i++) begin
            if (mod_index(s_axi_araddr) == i) begin
              if (mod_offset(s_axi_araddr) == 8'h00) s_axi_rdata[7:0] <= mm_r[i];
              if (mod_offset(s_axi_araddr) == OFF_CAP_LO) s_axi_rdata[7:0] <= cap_val[i][7:0];
              if (mod_offset(s_axi_araddr) == OFF_CAP_HI) s_axi_rdata[7:0] <= cap_val[i][15:8];
            end
          end
        end else begin
          s_axi_rresp <= RESP_SLVERR;
        end
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  hi_snapshot_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_lo |=> hi_snap_r == $past(count_r[15:8]))
    else $error("high byte snapshot not taken on low read");
  wrap_sets_flag_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    run && tick && count_r == 16'hFFFF |=> ovf_flag_r && count_r == 16'h0000)
    else $error("wrap did not set overflow flag");
  ovf_sticky_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ovf_flag_r && !ovf_clear |=> ovf_flag_r)
    else $error("overflow flag dropped without a software clear");
  idle_halt_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !run |=> count_r == $past(count_r))
    else $error("counter moved while halted in idle");
  count_step_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    run && tick |=> count_r == $past(count_r) + 16'h0001)
    else $error("counter did not advance on tick");
  div4_rate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    tb_sel == TB_DIV4 && $stable(tb_sel) && tick |=> !tick [*3])
    else $error("clock by four timebase ticked too fast");
  irq_gate_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    irq_r |-> $past(ie_r[IE_GLOBAL] && ie_r[IE_COUNTER]))
    else $error("interrupt raised while disabled");
  ovf_irq_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ovf_flag_r && mode_r[MODE_OVF_IE] && ie_r[IE_GLOBAL] && ie_r[IE_COUNTER] |=> irq_r)
    else $error("enabled overflow did not raise interrupt");
  wrap_cov: cover property (@(posedge sys_clk) disable iff (!rst_n) ovf_flag_r);
  snap_cov: cover property (@(posedge sys_clk) disable iff (!rst_n) rd_lo ##[1:20] rd_go);
  irq_cov: cover property (@(posedge sys_clk) disable iff (!rst_n) irq_r);
endmodule : counter_array
`default_nettype wire

// file: counter_array_partner.sv
// Far-side model: capture pins, count input, timer 0 overflow source and core interrupt logic.
`default_nettype none
module counter_array_partner (
  input  wire logic        sys_clk,
  input  wire logic        irq_r,
  output logic             timer0_overflow,
  output logic             external_count_input,
  output logic [1:0]       capture_pin,
  output logic [15:0]      vector_count_r
);
  timeunit 1ns;
  timeprecision 1ps;
  logic irq_d_r;
  initial begin
    timer0_overflow = 1'b0;
    external_count_input = 1'b1;
    capture_pin = 2'h0;
    vector_count_r = 16'h0000;
    irq_d_r = 1'b0;
  end
  // The core only counts vectors; it never touches a flag, so software must clear them.
  always @(posedge sys_clk) begin
    irq_d_r <= irq_r;
    if (irq_r && !irq_d_r) begin
      vector_count_r <= vector_count_r + 16'h0001;
    end
  end
  task automatic pulse_t0(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      timer0_overflow <= 1'b1;
      @(posedge sys_clk);
      if (gap > 0) begin
        timer0_overflow <= 1'b0;
        repeat (gap) @(posedge sys_clk);
      end
    end
    timer0_overflow <= 1'b0;
  endtask : pulse_t0
  // Falls come no faster than one per four clocks; the counter accepts up to one per two.
  task automatic fall_eci(input int n);
    repeat (n) begin
      external_count_input <= 1'b0;
      repeat (2) @(posedge sys_clk);
      external_count_input <= 1'b1;
      repeat (2) @(posedge sys_clk);
    end
  endtask : fall_eci
  // Pins are held long enough to pass the synchroniser before anyone looks.
  task automatic set_pin(input int m, input logic v);
    capture_pin[m] <= v;
    repeat (8) @(posedge sys_clk);
  endtask : set_pin
endmodule : counter_array_partner
`default_nettype wire

// file: test_counter_array_capture_timer.sv
// Self-checking bench for the counter array: timebases, captures, count reads and overflow.
`default_nettype none
module test_counter_array_capture_timer
  import counter_array_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk, resetn, core_idle, timer0_overflow, external_count_input, irq_r;
  logic [1:0]  capture_pin, s_axi_bresp, s_axi_rresp, r;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [15:0] vector_count_r, c0, c1, dc;
  int          err_total, comparisons, seed, k;

  counter_array i_counter_array (
    .sys_clk(sys_clk), .resetn(resetn), .core_idle(core_idle),
    .timer0_overflow(timer0_overflow), .external_count_input(external_count_input),
    .capture_pin(capture_pin), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .irq_r(irq_r)
  );
  counter_array_partner i_counter_array_partner (
    .sys_clk(sys_clk), .irq_r(irq_r), .timer0_overflow(timer0_overflow),
    .external_count_input(external_count_input), .capture_pin(capture_pin),
    .vector_count_r(vector_count_r)
  );

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic give_verdict();
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic chk_rng(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    comparisons++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk_rng

  // Both channels are offered together; each valid drops only at its own handshake edge.
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge sys_clk);
    n = 0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 60);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 60) chk(32'(n), 32'h0);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    int n;
    @(posedge sys_clk);
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 60);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 60) chk(32'(n), 32'h0);
  endtask : rd

  // Low byte first, so for the count the high byte comes from the snapshot taken with it.
  task automatic rd16(input logic [7:0] lo, input logic [7:0] hi, output logic [15:0] c);
    rd(lo, d, r);
    c[7:0] = d[7:0];
    rd(hi, d, r);
    c[15:8] = d[7:0];
  endtask : rd16

  function automatic logic [7:0] maddr(input int m, input logic [7:0] off);
    return 8'(OFF_MOD_BASE + OFF_MOD_STEP * m + off);
  endfunction : maddr

  initial begin
    // The wrap scenario alone needs about 65,000 cycles of timer 0 pulses.
    repeat (90000) @(posedge sys_clk);
    err_total++;
    give_verdict();
  end

  initial begin
    {resetn, core_idle, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 5'h00;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 18'h00000;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'h0;
    err_total = 0;
    comparisons = 0;
    seed = 32'h4cb387ca;
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rd(OFF_CONTROL, d, r);
    chk(d, 32'h0);
    rd(8'h14, d, r);
    chk(32'(r), 32'(RESP_SLVERR));
    wr(8'h14, 32'h0, r);
    chk(32'(r), 32'(RESP_SLVERR));
    core_idle <= 1'b1;
    for (int t = 0; t < 4; t++) begin
      k = 20 + int'({$random(seed)} % 30);
      wr(OFF_MODE, 32'(8'h80 | (t << 1)), r);
      rd16(OFF_CNT_LO, OFF_CNT_HI, c0);
      repeat (8) @(posedge sys_clk);
      rd16(OFF_CNT_LO, OFF_CNT_HI, c1);
      chk(32'(c1), 32'(c0));
      core_idle <= 1'b0;
      case (t)
        0: repeat (12 * k) @(posedge sys_clk);
        1: repeat (4 * k) @(posedge sys_clk);
        2: i_counter_array_partner.pulse_t0(k, 1);
        default: i_counter_array_partner.fall_eci(k);
      endcase
      repeat (6) @(posedge sys_clk);
      core_idle <= 1'b1;
      rd16(OFF_CNT_LO, OFF_CNT_HI, c1);
      dc = c1 - c0;
      chk_rng(32'(dc), 32'(k - (t < 2)), 32'(k + 3 * (t < 2)));
    end
    wr(OFF_MODE, 32'h02, r);
    rd16(OFF_CNT_LO, OFF_CNT_HI, c0);
    repeat (40) @(posedge sys_clk);
    rd16(OFF_CNT_LO, OFF_CNT_HI, c1);
    dc = c1 - c0;
    chk_rng(32'(dc), 32'd9, 32'd16);
    core_idle <= 1'b0;
    wr(OFF_MODE, 32'h04, r);
    rd16(OFF_CNT_LO, OFF_CNT_HI, c0);
    rd(OFF_CNT_LO, d, r);
    i_counter_array_partner.pulse_t0(256, 1);
    rd(OFF_CNT_HI, d, r);
    chk(d, 32'(c0[15:8]));
    rd16(OFF_CNT_LO, OFF_CNT_HI, c1);
    chk(32'(c1), 32'(c0 + 16'h0100));
    wr(OFF_IRQ_EN, 32'h81, r);
    for (int e = 1; e < 4; e++) begin
      for (int m = 0; m < 2; m++) begin
        wr(maddr(m, 8'h00), 32'(e << 4) | 32'h1, r);
        wr(OFF_CONTROL, 32'h0, r);
        rd16(OFF_CNT_LO, OFF_CNT_HI, c0);
        i_counter_array_partner.set_pin(m, 1'b1);
        rd(OFF_CONTROL, d, r);
        chk(32'(d[m]), 32'(e[1]));
        chk(32'(irq_r), 32'(e[1]));
        rd16(maddr(m, OFF_CAP_LO), maddr(m, OFF_CAP_HI), c1);
        if (e[1]) chk(32'(c1), 32'(c0));
        k = 1 + int'({$random(seed)} % 20);
        i_counter_array_partner.pulse_t0(k, 2);
        rd(OFF_CONTROL, d, r);
        chk(32'(d[m]), 32'(e[1]));
        wr(OFF_CONTROL, 32'h0, r);
        i_counter_array_partner.set_pin(m, 1'b0);
        rd(OFF_CONTROL, d, r);
        chk(32'(d[m]), 32'(e[0]));
        rd16(maddr(m, OFF_CAP_LO), maddr(m, OFF_CAP_HI), c1);
        if (e[0]) chk(32'(c1), 32'(c0 + 16'(k)));
      end
    end
    wr(OFF_CONTROL, 32'h0, r);
    wr(OFF_IRQ_EN, 32'h80, r);
    wr(OFF_MODE, 32'h05, r);
    rd16(OFF_CNT_LO, OFF_CNT_HI, c0);
    i_counter_array_partner.pulse_t0(65535 - int'(c0), 0);
    repeat (4) @(posedge sys_clk);
    rd(OFF_CONTROL, d, r);
    chk(32'(d[CTRL_OVF_FLAG]), 32'h0);
    i_counter_array_partner.pulse_t0(1, 0);
    repeat (4) @(posedge sys_clk);
    rd(OFF_CONTROL, d, r);
    chk(32'(d[CTRL_OVF_FLAG]), 32'h1);
    rd16(OFF_CNT_LO, OFF_CNT_HI, c1);
    chk(32'(c1), 32'h0);
    chk(32'(irq_r), 32'h0);
    wr(OFF_IRQ_EN, 32'h01, r);
    repeat (3) @(posedge sys_clk);
    chk(32'(irq_r), 32'h0);
    wr(OFF_IRQ_EN, 32'h81, r);
    repeat (3) @(posedge sys_clk);
    chk(32'(irq_r), 32'h1);
    wr(OFF_MODE, 32'h04, r);
    repeat (3) @(posedge sys_clk);
    chk(32'(irq_r), 32'h0);
    wr(OFF_MODE, 32'h05, r);
    repeat (3) @(posedge sys_clk);
    chk(32'(irq_r), 32'h1);
    rd(OFF_CONTROL, d, r);
    chk(32'(d[CTRL_OVF_FLAG] && vector_count_r != 16'h0), 32'h1);
    wr(OFF_CONTROL, 32'h0, r);
    repeat (3) @(posedge sys_clk);
    rd(OFF_CONTROL, d, r);
    chk(32'({d[CTRL_OVF_FLAG], irq_r}), 32'h0);
    give_verdict();
  end
endmodule : test_counter_array_capture_timer
`default_nettype wire
